// [hdl/fct_pkg.sv]
// Package: register map, reset values and carriers of the fan threshold bank
package fct_pkg;

    // ==================================================================
    // Register offsets
    localparam logic [7:0] FCT_R1_START_OFS = 8'h67;
    localparam logic [7:0] FCT_LC_START_OFS = 8'h68;
    localparam logic [7:0] FCT_R2_START_OFS = 8'h69;
    localparam logic [7:0] FCT_R1_CRIT_OFS = 8'h6a;
    localparam logic [7:0] FCT_LC_CRIT_OFS = 8'h6b;
    localparam logic [7:0] FCT_R2_CRIT_OFS = 8'h6c;
    localparam logic [7:0] FCT_HYST_A_OFS = 8'h6d;
    localparam logic [7:0] FCT_HYST_B_OFS = 8'h6e;
    localparam logic [7:0] FCT_TEST_OFS = 8'h6f;
    localparam logic [7:0] FCT_R1_TOFS_OFS = 8'h70;
    localparam logic [7:0] FCT_LC_TOFS_OFS = 8'h71;
    localparam logic [7:0] FCT_R2_TOFS_OFS = 8'h72;
    localparam logic [7:0] FCT_FIRST_OFS = FCT_R1_START_OFS;
    localparam logic [7:0] FCT_LAST_OFS = FCT_R2_TOFS_OFS;
    localparam int FCT_NREG = 12;

    // ==================================================================
    // Values after reset
    localparam logic [7:0] FCT_START_RST = 8'h5a;
    localparam logic [7:0] FCT_CRIT_RST = 8'h64;
    localparam logic [7:0] FCT_HYST_A_RST = 8'h44;
    localparam logic [7:0] FCT_HYST_B_RST = 8'h40;
    localparam logic [7:0] FCT_TEST_RST = 8'h00;
    localparam logic [7:0] FCT_TOFS_RST = 8'h00;
    localparam logic [7:0] FCT_RDATA_RST = 8'h00;

    // ==================================================================
    // Field positions and special values
    localparam int FCT_TEST_ON_BIT = 0;
    localparam logic [7:0] FCT_CRIT_OFF = 8'h80;
    localparam logic [7:0] FCT_DUTY_FULL = 8'hff;
    localparam logic [7:0] FCT_DUTY_OFF = 8'h00;

    // Channel numbers
    localparam logic [1:0] FCT_CH_R1 = 2'h0;
    localparam logic [1:0] FCT_CH_LC = 2'h1;
    localparam logic [1:0] FCT_CH_R2 = 2'h2;

    // ==================================================================
    // Carriers
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } fct_bus_s;

    // Temperature in quarter degrees, two's complement
    typedef struct packed {
        logic valid;
        logic [1:0] chan;
        logic [9:0] temp;
    } fct_meas_s;

endpackage

// [hdl/fct_bank.sv]
// Fan threshold configuration bank with start, failsafe and overtemp logic
//
// Notes on behaviour
// - Three fan start temperature registers at 0x67..0x69, reset 0x5a.
// - Above start temperature a fan runs at minimum duty, rising with heat.
// - Three critical limit registers at 0x6a..0x6c, reset 0x64.
// - Any channel over its critical limit forces all duty outputs full.
// - Critical limit of 0x80 disables the failsafe for that channel.
// - Full duty holds until temperature drops below limit minus hysteresis.
// - Overtemp pin, if an output, pulls low a quarter degree over limit.
// - 4-bit hysteresis per channel; 0x6d low local, high remote 1.
// - Hysteresis registers reset to 0x44 and 0x40.
// - Below start, fan stays at minimum until start minus hysteresis.
// - While locked, all bank registers ignore writes.
// - Bit 0 of test register enables gate tree test; reset 0x00.
// - Per-channel offset added to each measurement; offsets reset zero.
// - Offset range bit picks offset resolution.
// - Minimum duty scales linearly: 0x00 off, 0x80 half, 0xff full.
// - Remote 2 offset register at 0x72, resets to zero.
`timescale 1ns/1ps
module fct_bank
    import fct_pkg::*;
#(
    parameter int NCH = 3
) (
    // Clock and reset
    input wire logic CLOCK,
    input wire logic RESETN,
    // Register port
    input wire fct_pkg::fct_bus_s REG_BUS,
    output logic [7:0] RDATA,
    // Conversion results
    input wire fct_pkg::fct_meas_s MEAS,
    // Configuration from other banks
    input wire logic CFG_LOCK,
    input wire logic OFS_RANGE,
    input wire logic OT_PIN_IS_OUT,
    input wire logic [NCH-1:0][7:0] MIN_DUTY,
    input wire logic [NCH-1:0][3:0] SPAN_GAIN,
    // Fan control outputs
    output logic [NCH-1:0][7:0] DUTY,
    output logic [NCH-1:0] FAN_RUN,
    output logic FAILSAFE,
    output logic GATE_TREE_TEST_ON,
    // Overtemp pin, open drain
    output logic OT_PIN_O,
    output logic OT_PIN_OE
);
    import fct_pkg::*;

    // ==================================================================
    // Helpers
    function automatic logic [7:0] rst_val(input int idx);
        logic [7:0] ofs;
        ofs = FCT_FIRST_OFS + 8'(idx);
        if (ofs <= FCT_R2_START_OFS) begin
            return FCT_START_RST;
        end else if (ofs <= FCT_R2_CRIT_OFS) begin
            return FCT_CRIT_RST;
        end else if (ofs == FCT_HYST_A_OFS) begin
            return FCT_HYST_A_RST;
        end else if (ofs == FCT_HYST_B_OFS) begin
            return FCT_HYST_B_RST;
        end else if (ofs == FCT_TEST_OFS) begin
            return FCT_TEST_RST;
        end
        return FCT_TOFS_RST;
    endfunction

    // Degrees to signed quarter degrees
    function automatic logic signed [11:0] q4(input logic [7:0] deg);
        return $signed({{2{deg[7]}}, deg, 2'b00});
    endfunction

    function automatic logic signed [11:0] hq4(input logic [3:0] h);
        return $signed({6'h00, h, 2'b00});
    endfunction

    // Offset is in half degrees or whole degrees, per range bit
    function automatic logic signed [11:0] corr(input logic [9:0] t,
            input logic [7:0] ofs, input logic rng);
        logic signed [11:0] o;
        o = rng ? q4(ofs) : $signed({{3{ofs[7]}}, ofs, 1'b0});
        return $signed({{2{t[9]}}, t}) + o;
    endfunction

    // ==================================================================
    // Register storage
    logic [7:0] regs_ff [FCT_NREG];
    logic [7:0] rdata_ff;
    logic [7:0] widx;
    logic [7:0] ridx;
    logic wr_hit;
    logic rd_hit;

    assign widx = REG_BUS.addr - FCT_FIRST_OFS;
    assign ridx = widx;
    assign wr_hit = REG_BUS.wr && REG_BUS.addr >= FCT_FIRST_OFS
        && REG_BUS.addr <= FCT_LAST_OFS;
    assign rd_hit = REG_BUS.rd && REG_BUS.addr >= FCT_FIRST_OFS
        && REG_BUS.addr <= FCT_LAST_OFS;

    // Locked writes are dropped silently, no error path exists
    always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) begin
            for (int i = 0; i < FCT_NREG; i++) begin
                regs_ff[i] <= rst_val(i);
            end
        end else if (wr_hit && !CFG_LOCK) begin
            if (REG_BUS.addr == FCT_TEST_OFS) begin
                // Only the enable bit is kept; upper bits read zero
                regs_ff[widx[3:0]] <= {7'h00,
                    REG_BUS.wdata[FCT_TEST_ON_BIT]};
            end else begin
                regs_ff[widx[3:0]] <= REG_BUS.wdata;
            end
        end
    end

    always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) begin
            rdata_ff <= FCT_RDATA_RST;
        end else if (rd_hit) begin
            rdata_ff <= regs_ff[ridx[3:0]];
        end else begin
            rdata_ff <= FCT_RDATA_RST;
        end
    end

    assign RDATA = rdata_ff;

    // ==================================================================
    // Per-channel views of the registers
    logic [NCH-1:0][7:0] start_v;
    logic [NCH-1:0][7:0] crit_v;
    logic [NCH-1:0][7:0] tofs_v;
    logic [NCH-1:0][3:0] hyst_v;

    always_comb begin
        for (int c = 0; c < NCH; c++) begin
            start_v[c] = regs_ff[c];
            crit_v[c] = regs_ff[c + 3];
            tofs_v[c] = regs_ff[c + 9];
        end
        hyst_v[FCT_CH_R1] = regs_ff[6][7:4];
        hyst_v[FCT_CH_LC] = regs_ff[6][3:0];
        hyst_v[FCT_CH_R2] = regs_ff[7][7:4];
    end

    // ==================================================================
    // Comparison on each new conversion
    logic signed [11:0] t_corr;
    logic signed [11:0] st4;
    logic signed [11:0] cr4;
    logic signed [11:0] h4;
    logic [1:0] ch;

    assign ch = MEAS.chan;
    assign t_corr = corr(MEAS.temp, tofs_v[ch], OFS_RANGE);
    assign st4 = q4(start_v[ch]);
    assign cr4 = q4(crit_v[ch]);
    assign h4 = hq4(hyst_v[ch]);

    logic [NCH-1:0] run_ff;
    logic [NCH-1:0] crit_ff;
    logic [NCH-1:0] ot_ff;
    logic [NCH-1:0][7:0] exc_ff;

    // Fan start with hysteresis band below the start temperature
    always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) begin
            run_ff <= '0;
        end else if (MEAS.valid && ch < NCH) begin
            if (t_corr > st4) begin
                run_ff[ch] <= 1'b1;
            end else if (t_corr <= st4 - h4) begin
                run_ff[ch] <= 1'b0;
            end
        end
    end

    // Degrees above start, clamped to a byte, feed the ramp
    always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) begin
            exc_ff <= '0;
        end else if (MEAS.valid && ch < NCH) begin
            if (t_corr <= st4) begin
                exc_ff[ch] <= 8'h00;
            end else if (t_corr - st4 > 12'sh3fc) begin
                exc_ff[ch] <= 8'hff;
            end else begin
                exc_ff[ch] <= 8'(12'(t_corr - st4) >> 2);
            end
        end
    end

    // Critical failsafe per channel, released below limit minus hysteresis
    always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) begin
            crit_ff <= '0;
        end else if (MEAS.valid && ch < NCH) begin
            if (crit_v[ch] == FCT_CRIT_OFF) begin
                crit_ff[ch] <= 1'b0;
            end else if (t_corr > cr4) begin
                crit_ff[ch] <= 1'b1;
            end else if (t_corr < cr4 - h4) begin
                crit_ff[ch] <= 1'b0;
            end
        end
    end

    // Pin needs a full quarter degree above the limit
    always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) begin
            ot_ff <= '0;
        end else if (MEAS.valid && ch < NCH) begin
            if (crit_v[ch] == FCT_CRIT_OFF) begin
                ot_ff[ch] <= 1'b0;
            end else if (t_corr >= cr4 + 12'sh001) begin
                ot_ff[ch] <= 1'b1;
            end else if (t_corr < cr4 - h4) begin
                ot_ff[ch] <= 1'b0;
            end
        end
    end

    // ==================================================================
    // Duty outputs
    logic [NCH-1:0][7:0] duty_ff;
    logic failsafe_ff;
    logic ot_o_ff;
    logic ot_oe_ff;

    function automatic logic [7:0] ramp(input logic [7:0] mn,
            input logic [7:0] ex, input logic [3:0] g);
        logic [12:0] s;
        // Widen before multiplying so a large excess cannot wrap the product
        s = 13'(mn) + (13'(ex) * 13'(g));
        return (s > 13'h0ff) ? FCT_DUTY_FULL : s[7:0];
    endfunction

    always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) begin
            duty_ff <= '0;
        end else begin
            for (int c = 0; c < NCH; c++) begin
                if (|crit_ff) begin
                    duty_ff[c] <= FCT_DUTY_FULL;
                end else if (run_ff[c]) begin
                    duty_ff[c] <= ramp(MIN_DUTY[c], exc_ff[c],
                        SPAN_GAIN[c]);
                end else begin
                    duty_ff[c] <= FCT_DUTY_OFF;
                end
            end
        end
    end

    always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) begin
            failsafe_ff <= 1'b0;
        end else begin
            failsafe_ff <= |crit_ff;
        end
    end

    // Open drain: only ever pulls low
    always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) begin
            ot_o_ff <= 1'b0;
            ot_oe_ff <= 1'b0;
        end else begin
            ot_o_ff <= 1'b0;
            ot_oe_ff <= OT_PIN_IS_OUT && |ot_ff;
        end
    end

    assign DUTY = duty_ff;
    assign FAN_RUN = run_ff;
    assign FAILSAFE = failsafe_ff;
    assign GATE_TREE_TEST_ON = regs_ff[8][FCT_TEST_ON_BIT];
    assign OT_PIN_O = ot_o_ff;
    assign OT_PIN_OE = ot_oe_ff;

endmodule

// [verification/fct_bank_monitor.sv]
// Checker: port-level properties of the fan threshold bank
`timescale 1ns/1ps
module fct_bank_monitor
    import fct_pkg::*;
#(
    parameter int NCH = 3
) (
    // Clock, reset and register port
    input wire logic CLOCK,
    input wire logic RESETN,
    input wire fct_pkg::fct_bus_s REG_BUS,
    input wire logic [7:0] RDATA,
    // Measurement and configuration
    input wire fct_pkg::fct_meas_s MEAS,
    input wire logic CFG_LOCK,
    input wire logic OFS_RANGE,
    input wire logic OT_PIN_IS_OUT,
    input wire logic [NCH-1:0][7:0] MIN_DUTY,
    input wire logic [NCH-1:0][3:0] SPAN_GAIN,
    // Fan control outputs
    input wire logic [NCH-1:0][7:0] DUTY,
    input wire logic [NCH-1:0] FAN_RUN,
    input wire logic FAILSAFE,
    input wire logic GATE_TREE_TEST_ON,
    input wire logic OT_PIN_O,
    input wire logic OT_PIN_OE
);
    // ==================================================================
    // Properties
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (!RESETN);
    sequence s_test_wr(lk);
        REG_BUS.wr && REG_BUS.addr == FCT_TEST_OFS && CFG_LOCK == lk;
    endsequence
    sequence s_meas_lag;
        $past(MEAS.valid, 2);
    endsequence
    a_rdata_idle: assert property (!$past(REG_BUS.rd) |-> RDATA == 8'h00)
        else $error("read data not idle");
    a_fail_full: assert property (
        FAILSAFE |-> DUTY == {NCH{8'hff}}) else $error("failsafe not full");
    a_pin_low: assert property (OT_PIN_O == 1'b0)
        else $error("overtemp pin drives high");
    a_pin_needs_out: assert property (
        OT_PIN_OE |-> $past(OT_PIN_IS_OUT)) else $error("pin driven as input");
    a_test_bit: assert property (
        s_test_wr(1'b0) |=> GATE_TREE_TEST_ON == $past(REG_BUS.wdata[0]))
        else $error("test bit not taken");
    a_lock_test: assert property (
        s_test_wr(1'b1) |=> $stable(GATE_TREE_TEST_ON))
        else $error("locked write took effect");
    a_fail_lag: assert property ($rose(FAILSAFE) |-> s_meas_lag)
        else $error("failsafe rose without result");
    a_run_lag: assert property ($changed(FAN_RUN) |-> $past(MEAS.valid))
        else $error("run state moved without result");
    a_run_idle: assert property (
        !FAILSAFE && !$past(FAN_RUN[0]) |-> DUTY[0] == 8'h00)
        else $error("idle fan has duty");
    a_run_min: assert property (
        !FAILSAFE && $past(FAN_RUN[0]) |-> DUTY[0] >= MIN_DUTY[0])
        else $error("running fan below minimum");
endmodule

bind fct_bank fct_bank_monitor #(.NCH(NCH)) fct_bank_monitor_inst (
    .CLOCK(CLOCK), .RESETN(RESETN), .REG_BUS(REG_BUS), .RDATA(RDATA),
    .MEAS(MEAS), .CFG_LOCK(CFG_LOCK), .OFS_RANGE(OFS_RANGE),
    .OT_PIN_IS_OUT(OT_PIN_IS_OUT), .MIN_DUTY(MIN_DUTY),
    .SPAN_GAIN(SPAN_GAIN), .DUTY(DUTY), .FAN_RUN(FAN_RUN),
    .FAILSAFE(FAILSAFE), .GATE_TREE_TEST_ON(GATE_TREE_TEST_ON),
    .OT_PIN_O(OT_PIN_O), .OT_PIN_OE(OT_PIN_OE));

// [verification/fct_host_model.sv]
// Host model: software side of the register port
`timescale 1ns/1ps
module fct_host_model
    import fct_pkg::*;
(
    input wire logic clock,
    output fct_pkg::fct_bus_s bus,
    input wire logic [7:0] rdata
);
    // ==================================================================
    // Bus cycles; released lines show the inverse, never a stale copy
    initial bus = '0;
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        if (a == FCT_TEST_OFS) d[7:1] = 7'h00;
        if (a == FCT_HYST_A_OFS || a == FCT_HYST_B_OFS) begin
            for (int i = 0; i < 8; i += 4) begin
                if (d[i+:4] < 4'h4) d[i+:4] = 4'h4;
            end
        end
        @(posedge clock);
        bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge clock);
        bus <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clock);
        bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge clock);
        bus <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 8'hff};
        #1 d = rdata;
    endtask
endmodule

// [verification/test_fan_threshold_config_bank.sv]
// Testbench: register map, lock and threshold behaviour of the bank
`timescale 1ns/1ps
`define CHK(a, e, m) begin n_checks++; if ((a) !== (e)) begin \
    n_mismatch++; $display("MISMATCH %0t %s", $time, m); end end
module test_fan_threshold_config_bank;
    import fct_pkg::*;
    logic clock = 1'b0;
    logic resetn = 1'b0;
    fct_bus_s bus;
    fct_meas_s meas = '0;
    logic cfg_lock = 1'b0;
    logic ofs_range = 1'b0;
    logic ot_is_out = 1'b1;
    logic [2:0][7:0] min_duty = {3{8'h40}};
    logic [2:0][3:0] span_gain = 12'h002;
    logic [7:0] rdata;
    logic [7:0] d;
    logic [2:0][7:0] duty;
    logic [2:0] fan_run;
    logic failsafe, test_on, ot_o, ot_oe;
    int n_mismatch = 0;
    int n_checks = 0;
    logic [7:0] rst_val [12] = '{8'h5a, 8'h5a, 8'h5a, 8'h64, 8'h64, 8'h64,
        8'h44, 8'h40, 8'h00, 8'h00, 8'h00, 8'h00};

    always #20 clock = ~clock;

    fct_bank fct_bank_inst (.CLOCK(clock), .RESETN(resetn), .REG_BUS(bus),
        .RDATA(rdata), .MEAS(meas), .CFG_LOCK(cfg_lock),
        .OFS_RANGE(ofs_range), .OT_PIN_IS_OUT(ot_is_out),
        .MIN_DUTY(min_duty), .SPAN_GAIN(span_gain), .DUTY(duty),
        .FAN_RUN(fan_run), .FAILSAFE(failsafe), .GATE_TREE_TEST_ON(test_on),
        .OT_PIN_O(ot_o), .OT_PIN_OE(ot_oe));
    fct_host_model fct_host_model_inst (.clock(clock), .bus(bus),
        .rdata(rdata));

    // ==================================================================
    // Tasks
    task automatic do_reset;
        resetn <= 1'b0;
        repeat (5) @(posedge clock);
        resetn <= 1'b1;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        fct_host_model_inst.rd(a, d);
        `CHK(d, e, "read data")
    endtask
    // Result driven at c0, taken at c1; outputs sampled once settled after c3
    task automatic take(input logic [1:0] ch, input int deg);
        @(posedge clock);
        meas <= '{valid: 1'b1, chan: ch, temp: 10'(deg * 4)};
        @(posedge clock);
        meas.valid <= 1'b0;
        repeat (2) @(posedge clock);
        #1;
    endtask
    task automatic close_out;
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    initial begin
        repeat (5000) @(posedge clock);
        n_mismatch++;
        close_out;
    end

    // ==================================================================
    // Tests
    initial begin
        do_reset;
        for (int i = 0; i < 12; i++) begin
            rd_chk(8'h67 + 8'(i), rst_val[i]);
        end
        $display("test reset values done");
        for (int i = 0; i < 12; i++) begin
            fct_host_model_inst.wr(8'h67 + 8'(i), 8'h50 + 8'(i));
            rd_chk(8'h67 + 8'(i), (i == 8) ? 8'h00 : 8'h50 + 8'(i));
        end
        rd_chk(8'h73, 8'h00);
        cfg_lock <= 1'b1;
        for (int i = 0; i < 12; i++) begin
            fct_host_model_inst.wr(8'h67 + 8'(i), 8'h99);
            rd_chk(8'h67 + 8'(i), (i == 8) ? 8'h00 : 8'h50 + 8'(i));
        end
        cfg_lock <= 1'b0;
        $display("test access and lock done");
        do_reset;
        take(2'h0, 91);
        `CHK({fan_run[0], duty[0]}, 9'h142, "ramp above start")
        take(2'h0, 88);
        `CHK(fan_run[0], 1'b1, "run held in band")
        take(2'h0, 86);
        `CHK({fan_run[0], duty[0]}, 9'h000, "run released")
        fct_host_model_inst.wr(FCT_R1_TOFS_OFS, 8'h02);
        take(2'h0, 89);
        `CHK(fan_run[0], 1'b0, "half degree offset")
        ofs_range <= 1'b1;
        take(2'h0, 89);
        `CHK(fan_run[0], 1'b1, "full degree offset")
        fct_host_model_inst.wr(FCT_R1_TOFS_OFS, 8'h00);
        $display("test fan start done");
        take(2'h3, 120);
        `CHK(failsafe, 1'b0, "channel three ignored")
        take(2'h0, 101);
        `CHK({failsafe, ot_oe}, 2'b11, "failsafe on")
        `CHK(duty, {3{8'hff}}, "all duty full")
        take(2'h0, 97);
        `CHK(failsafe, 1'b1, "failsafe held")
        take(2'h0, 95);
        `CHK({failsafe, ot_oe}, 2'b00, "failsafe off")
        ot_is_out <= 1'b0;
        take(2'h1, 101);
        `CHK({failsafe, ot_oe}, 2'b10, "pin left as input")
        take(2'h1, 80);
        ot_is_out <= 1'b1;
        fct_host_model_inst.wr(FCT_R1_CRIT_OFS, 8'h80);
        take(2'h0, 120);
        `CHK(failsafe, 1'b0, "failsafe disabled")
        $display("test failsafe done");
        fct_host_model_inst.wr(FCT_TEST_OFS, 8'h01);
        #1 `CHK(test_on, 1'b1, "test mode on")
        fct_host_model_inst.wr(FCT_TEST_OFS, 8'h00);
        #1 `CHK(test_on, 1'b0, "test mode off")
        $display("test gate tree done");
        close_out;
    end
endmodule
